// >>> verilog/ncopm_defs.vh
`ifndef NCOPM_DEFS_VH
`define NCOPM_DEFS_VH

// register indices on the plain register port
`define NCOPM_ADDR_W        4
`define NCOPM_IDX_FREQ_WORD_ZERO     4'h0
`define NCOPM_IDX_FREQ_WORD_ONE     4'h1
`define NCOPM_IDX_PHASE0    4'h2
`define NCOPM_IDX_PHASE1    4'h3
`define NCOPM_IDX_PHASE2    4'h4
`define NCOPM_IDX_PHASE3    4'h5
`define NCOPM_IDX_ACC       4'h6

// field widths and positions
`define NCOPM_ACC_W         32
`define NCOPM_PH_W          12
`define NCOPM_PH_LSB        20
`define NCOPM_AMP_W         10
`define NCOPM_NUM_PH        4

// reset values
`define NCOPM_FREQ_RST      32'h00000000
`define NCOPM_PH_RST        12'h000
`define NCOPM_ACC_RST       32'h00000000
`define NCOPM_AMP_MID       10'h200

// pipeline length from sampled select to converter code
`define NCOPM_LATENCY       6

// sine approximation coefficients, scaled by 1024, and the 9-bit peak magnitude
`define NCOPM_COEF_LIN      11'h31A
`define NCOPM_COEF_SQ       11'h0E6
`define NCOPM_AMP_PEAK      9'h1FF

`endif

// >>> verilog/ncopm_top.v
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ncopm_defs.vh"

module ncopm_top (
  input  wire                      clk_i,
  input  wire                      resetn_i,
  input  wire                      sleep_n_i,
  input  wire                      freq_bank_select_i,
  input  wire                      phase_index_bit0_i,
  input  wire                      phase_index_bit1_i,
  input  wire [`NCOPM_ADDR_W-1:0]  reg_addr_i,
  input  wire [31:0]               reg_wdata_i,
  input  wire                      reg_wr_i,
  input  wire                      reg_rd_i,
  output reg  [31:0]               reg_rdata_o,
  output reg  [`NCOPM_AMP_W-1:0]   dac_code_o
);

  // sine of a 12-bit phase as offset-binary 10-bit code
  function [`NCOPM_AMP_W-1:0] ncopm_sine;
    input [`NCOPM_PH_W-1:0] ph;
    reg   [10:0]            h;
    reg   [11:0]            hc;
    reg   [20:0]            y;
    reg   [41:0]            y2;
    reg   [31:0]            s_acc;
    reg   [20:0]            s;
    reg   [29:0]            m;
    reg   [8:0]             mag;
    begin
      h     = ph[10:0];
      hc    = 12'h800 - {1'b0, h};
      // parabola 4x(1-x) over the half cycle, Q20; peak 2^20 fits 21 bits
      y     = h * hc;
      y2    = y * y;
      // refine toward a true sine: 0.775y + 0.225y^2, at most 2^30
      s_acc = (y * `NCOPM_COEF_LIN) + (y2[41:20] * `NCOPM_COEF_SQ);
      s     = s_acc[30:10];
      // scale to the 9-bit magnitude, at most 511 * 2^20
      m     = s * `NCOPM_AMP_PEAK;
      mag   = (m[29:20] > 10'h1FF) ? 9'h1FF : m[28:20];
      if (ph[11])
        ncopm_sine = `NCOPM_AMP_MID - {1'b0, mag};
      else
        ncopm_sine = `NCOPM_AMP_MID + {1'b0, mag};
    end
  endfunction

  reg  [`NCOPM_ACC_W-1:0]  freq_word_zero_reg;
  reg  [`NCOPM_ACC_W-1:0]  freq_word_one_reg;
  reg  [`NCOPM_PH_W-1:0]   phase_ofs_reg [0:`NCOPM_NUM_PH-1];
  reg  [`NCOPM_ACC_W-1:0]  step_reg;
  reg  [1:0]               psel_reg;
  reg  [`NCOPM_ACC_W-1:0]  acc_reg;
  reg  [`NCOPM_PH_W-1:0]   pofs_reg;
  reg  [`NCOPM_PH_W-1:0]   pm_addr_reg;
  reg  [`NCOPM_AMP_W-1:0]  lut_reg;
  reg  [`NCOPM_AMP_W-1:0]  hold_reg;
  wire                     run;
  wire [`NCOPM_ACC_W-1:0]  acc_next;
  wire [`NCOPM_PH_W-1:0]   pm_next;
  wire [`NCOPM_AMP_W-1:0]  lut_next;

  // sleep gates every datapath stage, as a stopped clock would
  // sleep freezes pipeline
  assign run = sleep_n_i;

  assign acc_next = acc_reg + step_reg;

  // offset on MSBs, keep top 12 bits as address
  assign pm_next = acc_reg[`NCOPM_ACC_W-1:`NCOPM_PH_LSB] + pofs_reg;

  assign lut_next = ncopm_sine(pm_addr_reg);

  // frequency word writes
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      freq_word_zero_reg <= `NCOPM_FREQ_RST;
      freq_word_one_reg  <= `NCOPM_FREQ_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `NCOPM_IDX_FREQ_WORD_ZERO)
        freq_word_zero_reg <= reg_wdata_i;
      if (reg_addr_i == `NCOPM_IDX_FREQ_WORD_ONE)
        freq_word_one_reg <= reg_wdata_i;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NCOPM_NUM_PH; gi = gi + 1) begin : g_phase
      // register index of this offset, cut to the address width on purpose
      localparam integer PH_IDX = `NCOPM_IDX_PHASE0 + gi;
      localparam [`NCOPM_ADDR_W-1:0] PH_ADDR = PH_IDX[`NCOPM_ADDR_W-1:0];
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
          phase_ofs_reg[gi] <= `NCOPM_PH_RST;
        else if (reg_wr_i && (reg_addr_i == PH_ADDR))
          phase_ofs_reg[gi] <= reg_wdata_i[`NCOPM_PH_W-1:0];
      end
    end
  endgenerate

  // stage 1: sample selects and latch the chosen step
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step_reg <= `NCOPM_FREQ_RST;
      psel_reg <= 2'h0;
    end else if (run) begin
      step_reg <= freq_bank_select_i ? freq_word_one_reg : freq_word_zero_reg;
      psel_reg <= {phase_index_bit1_i, phase_index_bit0_i};
    end
  end

  // stage 2: accumulate; a bank switch only changes the step
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg  <= `NCOPM_ACC_RST;
      pofs_reg <= `NCOPM_PH_RST;
    end else if (run) begin
      // once per clock, no reload on switch
      acc_reg  <= acc_next;
      pofs_reg <= phase_ofs_reg[psel_reg];
    end
  end

  // stages 3 to 6: modulate, look up, align, drive converter
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pm_addr_reg <= `NCOPM_PH_RST;
      lut_reg     <= `NCOPM_AMP_MID;
      hold_reg    <= `NCOPM_AMP_MID;
      dac_code_o  <= `NCOPM_AMP_MID;
    end else if (run) begin
      pm_addr_reg <= pm_next;
      lut_reg     <= lut_next;
      hold_reg    <= lut_reg;
      // fresh code each clock, sixth stage
      dac_code_o  <= hold_reg;
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `NCOPM_IDX_FREQ_WORD_ZERO:  reg_rdata_o <= freq_word_zero_reg;
        `NCOPM_IDX_FREQ_WORD_ONE:  reg_rdata_o <= freq_word_one_reg;
        `NCOPM_IDX_PHASE0: reg_rdata_o <= {20'h00000, phase_ofs_reg[0]};
        `NCOPM_IDX_PHASE1: reg_rdata_o <= {20'h00000, phase_ofs_reg[1]};
        `NCOPM_IDX_PHASE2: reg_rdata_o <= {20'h00000, phase_ofs_reg[2]};
        `NCOPM_IDX_PHASE3: reg_rdata_o <= {20'h00000, phase_ofs_reg[3]};
        `NCOPM_IDX_ACC:    reg_rdata_o <= acc_reg;
        default:           reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule // ncopm_top

`default_nettype wire

// >>> bench/ncopm_host.sv
`timescale 1ns/10ps
`default_nettype none
// processor side driving the select pins
module ncopm_host (
  input  wire logic       fsel_i,
  input  wire logic [1:0] idx_i,
  output wire logic [2:0] sel_o
);
  assign sel_o = {fsel_i, idx_i};
endmodule // ncopm_host
`default_nettype wire

// >>> bench/ncopm_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ncopm_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        sleep_n_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [9:0]  dac_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic seen_reg;
  // any write since reset
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) seen_reg <= 1'b0;
    else if (reg_wr_i) seen_reg <= 1'b1;
  // accumulator read while asleep
  sequence s_rd;
    reg_rd_i && reg_addr_i == 4'h6 && !sleep_n_i;
  endsequence
  a_rd_idle: assert property (!reg_rd_i |=> !reg_rdata_o) else $error("rdata");
  a_sleep_hold: assert property (!sleep_n_i |=> $stable(dac_code_o)) else $error("sleep");
  a_unmapped_rd: assert property (reg_rd_i && reg_addr_i > 6 |=> !reg_rdata_o)
    else $error("unmapped");
  a_ofs_width: assert property (reg_rd_i && reg_addr_i inside {[2:5]} |=> !reg_rdata_o[31:12])
    else $error("width");
  a_acc_frozen: assert property (s_rd ##1 s_rd |=> $stable(reg_rdata_o)) else $error("acc");
  a_acc_ro: assert property (s_rd ##1 (reg_wr_i && !sleep_n_i) ##1 s_rd
    |=> reg_rdata_o == $past(reg_rdata_o, 2)) else $error("acc written");
  a_rst_zero: assert property (reg_rd_i && reg_addr_i == 6 && !seen_reg |=> !reg_rdata_o)
    else $error("acc reset");
  a_rst_mid: assert property (!seen_reg |-> dac_code_o == 10'h200) else $error("mid");
endmodule // ncopm_chk
bind ncopm_top ncopm_chk u_ncopm_chk (.clk_i, .resetn_i, .sleep_n_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .dac_code_o);
`default_nettype wire

// >>> bench/ncopm_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ncopm_top_tb;
  logic        clk, rst_n, sleep_n, fsel, wr, rd;
  logic [1:0]  idx;
  logic [2:0]  sel;
  logic [3:0]  addr;
  logic [31:0] wd, rdata, q, a0;
  logic [9:0]  dac, d0;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  ncopm_host u_ncopm_host (.fsel_i(fsel), .idx_i(idx), .sel_o(sel));
  ncopm_top u_ncopm_top (.clk_i(clk), .resetn_i(rst_n), .sleep_n_i(sleep_n),
    .freq_bank_select_i(sel[2]), .phase_index_bit0_i(sel[0]), .phase_index_bit1_i(sel[1]),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .dac_code_o(dac));
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  // one bus cycle; q takes the answer to the previous read
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d = 0);
    wr <= w;
    rd <= r;
    addr <= a;
    wd <= d;
    @(posedge clk);
    q = rdata;
  endtask
  task automatic nap(input int n);
    repeat (n) op(0, 0, 0);
  endtask
  // offset index i sits at gray(i) quarter turns
  task automatic lvl(input int i);
    logic [9:0] e;
    e = (i ^ i >> 1) == 1 ? 10'h3FF : (i ^ i >> 1) == 3 ? 10'h001 : 10'h200;
    chk(32'(dac + 10'd4 - e <= 10'd8), 1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {wr, rd, fsel, idx, addr, wd, rst_n} = '0;
    sleep_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    nap(2);
    op(0, 1, 6);
    nap(1);
    chk(q, 0);
    chk(dac, 10'h200);
    op(1, 0, 2, '1);
    op(0, 1, 2);
    op(0, 1, 9);
    chk(q, 32'hFFF);
    nap(1);
    chk(q, 0);
    for (int i = 0; i < 4; i++) op(1, 0, 4'(i + 2), 32'(12'h400 * (i ^ i >> 1)));
    for (int i = 1; i < 4; i++) begin
      idx <= 2'(i);
      nap(6);
      lvl(i - 1);
      nap(1);
      lvl(i);
    end
    op(1, 0, 0, 32'h10000000);
    op(1, 0, 1, 32'hF0000001);
    for (int f = 0; f < 2; f++) begin
      fsel <= f[0];
      nap(3);
      op(0, 1, 6);
      op(0, 1, 6);
      a0 = q;
      nap(1);
      chk(q - a0, f ? 32'hF0000001 : 32'h10000000);
    end
    d0 = dac;
    nap(1);
    chk(dac !== d0, 1);
    sleep_n <= 1'b0;
    nap(2);
    d0 = dac;
    op(0, 1, 6);
    op(0, 1, 6);
    op(1, 0, 6, 1);
    a0 = q;
    op(0, 1, 6);
    nap(1);
    chk(q, a0);
    chk(dac, d0);
    results();
  end
endmodule // ncopm_top_tb
`default_nettype wire
